//--- iso_rx_consts.svh
// constants for the isochronous receiver event and status block
// How it works
// [R1] stamp fifo overrun sets flag bit 14
// [R2] that flag warns up to seven syncs lost
// [R3] hundred quadlets left sets bit 10
// [R4] 256 quadlets left sets bit 9
// [R5] 512 left sets bit 8, not at half-k
// [R6] memory bank full sets fatal bit 7
// [R7] memory bank empty sets bit 6
// [R8] each frame sync pulse sets bit 5
// [R9] out of sequence blocks set bit 4
// [R10] crc failure sets bit 3
// [R11] bad header tag drops packet, bit 2
// [R12] each finished packet sets bit 1
// [R13] status queue overrun sets fatal bit 0
// [R14] host resets receiver after fatal events
// [R15] one enable bit per flag, 14..0
// [R16] two-bit speed field of last packet
// [R17] accept packets whose tag matches field
// [R18] four-bit error code at bits 7..4
// [R19] sync bit follows its payload, bit 0
// [R20] output sync may lag register sync
// [R21] flags stick until host writes one
`ifndef ISO_RX_CONSTS_SVH
`define ISO_RX_CONSTS_SVH
`define OFS_EVENT_FLAGS    8'h4c
`define OFS_EVENT_MASK     8'h50
`define OFS_CONTROL_STATUS 8'h54
`define EVENT_MASK_BITS    32'h00007fff
`define BIT_STAMP_OVR      14
`define BIT_LEFT_100       10
`define BIT_LEFT_256       9
`define BIT_LEFT_512       8
`define BIT_FULL           7
`define BIT_EMPTY          6
`define BIT_FSYNC          5
`define BIT_SEQ            4
`define BIT_CRC            3
`define BIT_HDR            2
`define BIT_DONE           1
`define BIT_STATUS_QUEUE_OVERRUN_FLAG           0
`define LEFT_100           100
`define LEFT_256           256
`define LEFT_512           512
`define STAMP_LOST_MAX     7
`define RESET_WORD         32'h00000000
`endif

//--- iso_rx_event_status.sv
// event flags, enables and control/status of the isochronous receiver
`timescale 1ns/1ps
`default_nettype none
`include "iso_rx_consts.svh"

module iso_rx_event_status #(
    parameter int QUEUE_DEPTH = 2048,
    parameter int FILL_W      = 12
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    input  wire iso_rx_pkg::reg_req_t     reg_req,
    output logic [31:0]                   rdata,
    input  wire iso_rx_pkg::pkt_status_t  pkt_status,
    input  wire logic [FILL_W-1:0]        queue_fill,
    input  wire logic                     half_k_buffer,
    input  wire logic                     stamp_fifo_overrun,
    input  wire logic                     status_queue_overrun,
    input  wire logic                     frame_sync_output,
    input  wire logic                     fifo_sync_out,
    output logic                          stamp_fifo_clear,
    output logic                          pkt_accept,
    output logic                          pkt_discard,
    output logic                          av_sync_out,
    output logic                          irq
);

    ////////////////////////////////////////////////////////////////////////
    // fill level thresholds
    logic [FILL_W-1:0] space_left;
    logic [14:0]       events;
    logic              left_100_r;
    logic              left_256_r;
    logic              left_512_r;
    logic              full_r;
    logic              empty_r;
    logic              at_100;
    logic              at_256;
    logic              at_512;
    logic              is_full;
    logic              is_empty;

    assign space_left = FILL_W'(QUEUE_DEPTH) - queue_fill;
    assign at_100   = space_left <= FILL_W'(`LEFT_100);  // [R3]
    assign at_256   = space_left <= FILL_W'(`LEFT_256);  // [R4]
    // half-k buffer never raises the 512 event
    assign at_512   = (space_left <= FILL_W'(`LEFT_512))
                      && !half_k_buffer;                 // [R5]
    assign is_full  = space_left == '0;                  // [R6]
    assign is_empty = queue_fill == '0;                  // [R7]

    // level history so each crossing is one event, not a stream
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            left_100_r <= 1'b0;
            left_256_r <= 1'b0;
            left_512_r <= 1'b0;
            full_r     <= 1'b0;
            empty_r    <= 1'b1;
        end else begin
            left_100_r <= at_100;
            left_256_r <= at_256;
            left_512_r <= at_512;
            full_r     <= is_full;
            empty_r    <= is_empty;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // packet acceptance by tag match
    logic [1:0] tag_r;
    logic       tag_ok;
    assign tag_ok = pkt_status.tag == tag_r;             // [R17]

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pkt_accept  <= 1'b0;
            pkt_discard <= 1'b0;
        end else begin
            pkt_accept  <= pkt_status.valid && tag_ok
                           && !pkt_status.hdr_bad;       // [R17]
            // a bad header throws away the whole packet
            pkt_discard <= pkt_status.valid
                           && (pkt_status.hdr_bad || !tag_ok); // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // raw event vector, one pulse per cause
    always_comb begin
        events = '0;
        // a stamp overrun may cost up to seven sync pulses
        events[`BIT_STAMP_OVR] = stamp_fifo_overrun;            // [R1] [R2]
        events[`BIT_LEFT_100]  = at_100 && !left_100_r;              // [R3]
        events[`BIT_LEFT_256]  = at_256 && !left_256_r;              // [R4]
        events[`BIT_LEFT_512]  = at_512 && !left_512_r;              // [R5]
        events[`BIT_FULL]      = is_full && !full_r;                 // [R6]
        events[`BIT_EMPTY]     = is_empty && !empty_r;               // [R7]
        events[`BIT_FSYNC]     = frame_sync_output;                  // [R8]
        events[`BIT_SEQ] = pkt_status.valid && pkt_status.seq_bad; // [R9]
        events[`BIT_CRC] = pkt_status.valid && pkt_status.crc_bad; // [R10]
        events[`BIT_HDR] = pkt_status.valid && pkt_status.hdr_bad; // [R11]
        events[`BIT_DONE]      = pkt_status.valid;                   // [R12]
        events[`BIT_STATUS_QUEUE_OVERRUN_FLAG]      = status_queue_overrun;               // [R13]
    end

    // overrun empties the stamp fifo on the very next edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stamp_fifo_clear <= 1'b0;
        end else begin
            stamp_fifo_clear <= stamp_fifo_overrun;      // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags and enables
    logic [14:0] flags_r;
    logic [14:0] flags_nxt;
    logic [14:0] mask_r;
    logic        wr_flags;
    logic        wr_mask;
    logic        wr_ctl;

    assign wr_flags = reg_req.wr && reg_req.addr == `OFS_EVENT_FLAGS;
    assign wr_mask  = reg_req.wr && reg_req.addr == `OFS_EVENT_MASK;
    assign wr_ctl   = reg_req.wr && reg_req.addr == `OFS_CONTROL_STATUS;

    // write one to clear; a new event in the same cycle wins
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = flags_r & ~reg_req.wdata[14:0];  // [R21]
        end
        flags_nxt = flags_nxt | events;                  // [R21]
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= '0;
        end else if (wr_mask) begin
            mask_r <= reg_req.wdata[14:0];               // [R15]
        end
    end

    // interrupt follows the flags that will be held next cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_nxt & mask_r);                // [R15] [R21]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control/status: tag setting and last packet report
    logic [1:0] speed_r;
    logic [3:0] err_r;
    logic       sync_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tag_r <= 2'h0;
        end else if (wr_ctl) begin
            tag_r <= reg_req.wdata[15:14];               // [R17]
        end
    end

    // status of the last packet; read-only, writes do not touch it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            speed_r <= 2'h0;
            err_r   <= 4'h0;
            sync_r  <= 1'b0;
        end else if (pkt_status.valid) begin
            speed_r <= pkt_status.speed;                 // [R16]
            err_r   <= pkt_status.err_code;              // [R18]
            sync_r  <= pkt_status.sync_bit;              // [R19]
        end
    end

    // port sync comes from the fifo head, so it can lag the register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            av_sync_out <= 1'b0;
        end else begin
            av_sync_out <= fifo_sync_out;                // [R20]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe, zero elsewhere
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= `RESET_WORD;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                `OFS_EVENT_FLAGS:    rdata <= {17'h0, flags_r};
                `OFS_EVENT_MASK:     rdata <= {17'h0, mask_r};
                `OFS_CONTROL_STATUS: rdata <= {14'h0, speed_r, tag_r,
                                               6'h0, err_r, 3'h0, sync_r};
                default:             rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // sticky flags: only a write of one may drop a raised flag
    a_flag_sticks: assert property ( // [R21]
        @(posedge sys_clk) disable iff (!rstn)
        (flags_r[`BIT_FULL] && !wr_flags) |=> flags_r[`BIT_FULL])
        else $error("full flag dropped without a write");
    a_flag_clears: assert property ( // [R21]
        @(posedge sys_clk) disable iff (!rstn)
        (wr_flags && reg_req.wdata[`BIT_FULL] && !events[`BIT_FULL])
        |=> !flags_r[`BIT_FULL])
        else $error("full flag not cleared by a write of one");
    // lost syncs are only known if the overrun flag survives them
    a_stamp_holds: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!rstn)
        (flags_r[`BIT_STAMP_OVR] && !wr_flags) |=> flags_r[`BIT_STAMP_OVR])
        else $error("stamp overrun flag dropped without a write");

    // pulse events land in the flags one edge later
    a_stamp_sets: assert property ( // [R1]
        @(posedge sys_clk) disable iff (!rstn)
        stamp_fifo_overrun |=> flags_r[14] && stamp_fifo_clear)
        else $error("stamp overrun not flagged or cleared");
    a_clear_only: assert property ( // [R1]
        @(posedge sys_clk) disable iff (!rstn)
        !stamp_fifo_overrun |=> !stamp_fifo_clear)
        else $error("stamp fifo cleared without an overrun");
    a_done_sets: assert property ( // [R12]
        @(posedge sys_clk) disable iff (!rstn)
        pkt_status.valid |=> flags_r[1])
        else $error("packet done not flagged");
    a_status_queue_overrun_flag_sets: assert property ( // [R13]
        @(posedge sys_clk) disable iff (!rstn)
        status_queue_overrun |=> flags_r[0])
        else $error("status overrun not flagged");
    a_fsync_sets: assert property ( // [R8]
        @(posedge sys_clk) disable iff (!rstn)
        frame_sync_output |=> flags_r[5])
        else $error("frame sync not flagged");
    a_seq_sets: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!rstn)
        (pkt_status.valid && pkt_status.seq_bad) |=> flags_r[`BIT_SEQ])
        else $error("sequence fault not flagged");
    a_crc_sets: assert property ( // [R10]
        @(posedge sys_clk) disable iff (!rstn)
        (pkt_status.valid && pkt_status.crc_bad) |=> flags_r[`BIT_CRC])
        else $error("checksum fault not flagged");

    // level crossings raise one event each
    a_left_100_sets: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!rstn)
        (at_100 && !left_100_r) |=> flags_r[`BIT_LEFT_100])
        else $error("100-left crossing not flagged");
    a_left_256_sets: assert property ( // [R4]
        @(posedge sys_clk) disable iff (!rstn)
        (at_256 && !left_256_r) |=> flags_r[`BIT_LEFT_256])
        else $error("256-left crossing not flagged");
    a_left_512_sets: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!rstn)
        (at_512 && !left_512_r) |=> flags_r[`BIT_LEFT_512])
        else $error("512-left crossing not flagged");
    a_half_k_off: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!rstn)
        half_k_buffer |-> !events[8])
        else $error("512 event with half-k buffer");
    a_full_sets: assert property ( // [R6]
        @(posedge sys_clk) disable iff (!rstn)
        (queue_fill == FILL_W'(QUEUE_DEPTH) && !full_r) |=> flags_r[7])
        else $error("full memory not flagged");
    a_empty_sets: assert property ( // [R7]
        @(posedge sys_clk) disable iff (!rstn)
        (queue_fill == '0 && !empty_r) |=> flags_r[`BIT_EMPTY])
        else $error("empty memory not flagged");

    // enables and the interrupt line
    a_irq_gated: assert property ( // [R15]
        @(posedge sys_clk) disable iff (!rstn)
        irq == |(flags_r & $past(mask_r)))
        else $error("interrupt not matching flags and enables");
    a_irq_masked: assert property ( // [R15]
        @(posedge sys_clk) disable iff (!rstn)
        (mask_r == 15'h0000) |=> !irq)
        else $error("interrupt with every enable off");
    a_mask_write: assert property ( // [R15]
        @(posedge sys_clk) disable iff (!rstn)
        wr_mask |=> mask_r == $past(reg_req.wdata[14:0]))
        else $error("enable write not taken");

    // tag filter and header faults
    a_tag_drop: assert property ( // [R17]
        @(posedge sys_clk) disable iff (!rstn)
        (pkt_status.valid && pkt_status.tag != tag_r) |=> pkt_discard
        && !pkt_accept)
        else $error("tag mismatch not discarded");
    a_accept_ok: assert property ( // [R17]
        @(posedge sys_clk) disable iff (!rstn)
        (pkt_status.valid && pkt_status.tag == tag_r
         && !pkt_status.hdr_bad) |=> pkt_accept && !pkt_discard)
        else $error("matching packet not accepted");
    a_hdr_sets: assert property ( // [R11]
        @(posedge sys_clk) disable iff (!rstn)
        (pkt_status.valid && pkt_status.hdr_bad) |=> flags_r[2]
        && pkt_discard)
        else $error("header fault not flagged");
    a_tag_write: assert property ( // [R17]
        @(posedge sys_clk) disable iff (!rstn)
        wr_ctl |=> tag_r == $past(reg_req.wdata[15:14]))
        else $error("tag write not taken");

    // last packet report and the port sync
    a_speed_kept: assert property ( // [R16]
        @(posedge sys_clk) disable iff (!rstn)
        pkt_status.valid |=> speed_r == $past(pkt_status.speed)
        && err_r == $past(pkt_status.err_code))
        else $error("speed or error code not captured");
    a_sync_kept: assert property ( // [R19]
        @(posedge sys_clk) disable iff (!rstn)
        pkt_status.valid |=> sync_r == $past(pkt_status.sync_bit))
        else $error("sync bit not captured");
    a_ro_fields: assert property ( // [R18]
        @(posedge sys_clk) disable iff (!rstn)
        (wr_ctl && !pkt_status.valid) |=> $stable(speed_r)
        && $stable(err_r) && $stable(sync_r))
        else $error("read-only status changed by a write");
    // the edge right after reset is skipped, its history is unknown
    a_av_sync: assert property ( // [R20]
        @(posedge sys_clk) disable iff (!rstn)
        $past(rstn) |-> av_sync_out == $past(fifo_sync_out))
        else $error("port sync not one cycle behind fifo head");

    // read data stands only in the cycle after a read strobe
    a_rdata_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !reg_req.rd |=> rdata == 32'h00000000)
        else $error("read data outside the answer cycle");

endmodule : iso_rx_event_status
`default_nettype wire

//--- iso_rx_host.sv
// host controller model driving the receiver register port
`timescale 1ns/1ps
`default_nettype none
`include "iso_rx_consts.svh"
module iso_rx_host (
    input  wire logic                sys_clk,
    input  wire logic [31:0]         rdata,
    output var iso_rx_pkg::reg_req_t reg_req
);
    ////////////////////////////////////////
    // write strobe, then a quiet cycle so a task never re-drives in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_req <= '{a, v, 1'b1, 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1 v = rdata;
        @(posedge sys_clk);
    endtask : rd
    // acknowledge by writing ones to the event flags register
    task automatic ack(input logic [31:0] m);
        wr(`OFS_EVENT_FLAGS, m);
    endtask : ack
    initial reg_req = '0;
endmodule : iso_rx_host
`default_nettype wire

//--- iso_rx_pkg.sv
// types shared by the isochronous receiver event block
package iso_rx_pkg;
    // one received packet's status as the link core hands it over
    typedef struct packed {
        logic       valid;
        logic [1:0] speed;
        logic [1:0] tag;
        logic [3:0] err_code;
        logic       sync_bit;
        logic       crc_bad;
        logic       hdr_bad;
        logic       seq_bad;
    } pkt_status_t;
    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
endpackage : iso_rx_pkg

//--- test_iso_rx_event_status.sv
// self-checking bench for the receiver event and status block
`timescale 1ns/1ps
`default_nettype none
`include "iso_rx_consts.svh"
module test_iso_rx_event_status;
    logic                    sys_clk;
    logic                    rstn;
    iso_rx_pkg::reg_req_t    reg_req;
    iso_rx_pkg::pkt_status_t pkt_status;
    logic [31:0]             rdata;
    logic [11:0]             queue_fill;
    logic                    half_k_buffer;
    logic [2:0]              ev;
    logic                    fifo_sync_out;
    logic                    stamp_fifo_clear;
    logic                    pkt_accept;
    logic                    pkt_discard;
    logic                    av_sync_out;
    logic                    irq;
    logic [31:0]             d;
    int                      failures;
    int                      n_tests;
    int                      cycles;

    iso_rx_event_status DUT (.sys_clk(sys_clk), .rstn(rstn),
        .reg_req(reg_req), .rdata(rdata), .pkt_status(pkt_status),
        .queue_fill(queue_fill), .half_k_buffer(half_k_buffer),
        .stamp_fifo_overrun(ev[0]), .status_queue_overrun(ev[1]),
        .frame_sync_output(ev[2]), .fifo_sync_out(fifo_sync_out),
        .stamp_fifo_clear(stamp_fifo_clear), .pkt_accept(pkt_accept),
        .pkt_discard(pkt_discard), .av_sync_out(av_sync_out), .irq(irq));
    iso_rx_host host (.sys_clk(sys_clk), .rdata(rdata), .reg_req(reg_req));

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    // a hang is cut off well past the roughly 160 cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk
    // exact flag word (ig bits not judged), irq follows, then all acked
    task automatic flags_are(input logic [31:0] e, input logic [31:0] ig);
        host.rd(`OFS_EVENT_FLAGS, d);
        chk("flags", e, d & ~ig);
        chk("irq", {31'h0, d != 0}, {31'h0, irq});
        host.ack(32'h7fff);
        #1 chk("irq_low", 32'h0, {31'h0, irq});
        @(posedge sys_clk);
    endtask : flags_are
    ////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] ofs[4] = '{8'h4c, 8'h50, 8'h54, 8'h58};
        for (int i = 0; i < 4; i++) begin
            host.rd(ofs[i], d);
            chk("reset_word", `RESET_WORD, d);
        end
        host.wr(`OFS_EVENT_MASK, 32'hffffffff);
        host.rd(`OFS_EVENT_MASK, d);
        chk("mask", `EVENT_MASK_BITS, d);
        host.wr(`OFS_CONTROL_STATUS, 32'hffffffff);
        host.rd(`OFS_CONTROL_STATUS, d);
        chk("ctl_rw", 32'h0000c000, d);
        host.wr(`OFS_CONTROL_STATUS, 32'h00004000);
    endtask : t_regs
    // stamp overrun, status queue overrun, frame sync pulses
    task automatic t_pulses();
        int bits[3] = '{14, 0, 5};
        for (int k = 0; k < 3; k++) begin
            ev[k] <= 1'b1;
            @(posedge sys_clk);
            ev[k] <= 1'b0;
            #1 chk("fifo_clr", {31'h0, k == 0},
                   {31'h0, stamp_fifo_clear});
            @(posedge sys_clk);
            flags_are(32'h1 << bits[k], 32'h0);
        end
    endtask : t_pulses
    task automatic send(input logic [1:0] sp, input logic [1:0] tg,
                        input logic [2:0] bad, input logic ok);
        pkt_status <= '{1'b1, sp, tg, 4'hd, sp[0], bad[2], bad[1], bad[0]};
        @(posedge sys_clk);
        pkt_status.valid <= 1'b0;
        #1 chk("accept", {31'h0, ok}, {31'h0, pkt_accept});
        chk("discard", {31'h0, !ok}, {31'h0, pkt_discard});
        @(posedge sys_clk);
    endtask : send
    task automatic t_packet();
        for (int s = 0; s < 4; s++) begin
            send(s[1:0], 2'b01, 3'b101, 1'b1);
            host.rd(`OFS_CONTROL_STATUS, d);
            chk("ctl", {14'h0, s[1:0], 8'h40, 7'h68, s[0]},
                d);
            flags_are(32'h1a, 32'h0);
        end
        send(2'b00, 2'b01, 3'b010, 1'b0);
        flags_are(32'h4, 32'h2);
        send(2'b00, 2'b10, 3'b000, 1'b0);
        flags_are(32'h0, 32'h2);
        fifo_sync_out <= 1'b1;
        @(posedge sys_clk);
        #1 chk("av_sync", 32'h1, {31'h0, av_sync_out});
        @(posedge sys_clk);
    endtask : t_packet
    task automatic fill(input logic [11:0] v, input logic [31:0] e);
        queue_fill <= v;
        repeat (2) @(posedge sys_clk);
        flags_are(e, 32'h0);
    endtask : fill
    task automatic t_queue();
        half_k_buffer <= 1'b1;
        fill(12'd1536, 32'h0);
        fill(12'd1792, 32'h200);
        fill(12'd1948, 32'h400);
        fill(12'd2048, 32'h80);
        fill(12'd0, 32'h40);
        half_k_buffer <= 1'b0;
        fill(12'd1536, 32'h100);
        fill(12'd2048, 32'h680);
        // fatal state: host restarts, which also empties the queue
        rstn <= 1'b0;
        queue_fill <= 12'h000;
        @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        host.rd(`OFS_EVENT_FLAGS, d);
        chk("restart", `RESET_WORD, d);
    endtask : t_queue
    ////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        pkt_status = '0;
        queue_fill = 12'h000;
        half_k_buffer = 1'b0;
        ev = 3'h0;
        fifo_sync_out = 1'b0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_pulses();
        t_packet();
        t_queue();
        report_and_stop();
    end
endmodule : test_iso_rx_event_status
`default_nettype wire
